// ---- design/dps_supervisor.sv ----
// Purpose: Protection supervisor for a motor inverter, APB register slave
// Assumes: Measurements arrive on the block clock; fault pins are asynchronous
// Notes: Currents in 0.1 % of drive rating, frequency in 0.01 Hz
// Functional notes
// [R1] Trip level is min of own level and motor current times gain, 300 % default.
// [R2] Gain applies only in open-loop magnet motor control; 100 % equals rated current.
// [R3] Unbalance enable 1 (default): unbalance raises fault and output coasts off.
// [R4] Unbalance enable 0: no unbalance check, fault never raised.
// [R5] Supply failure action 0: ramp stop on normal decel time; range 0-4, default 1.
// [R6] Action 1: output off immediately, motor coasts.
// [R7] Action 2: stop on quick stop time.
// [R8] Action 3: keep running, alarm shown on operator keypad.
// [R9] Action 4: keep running at reduced speed rate.
// [R10] Supply failure is an error for actions 0, 2 and an alarm for 3, 4.
// [R11] Mounting style accepts only 0, 2, 3; parameter init leaves it unchanged.
// [R12] Derate select 0: never lower carrier for high current.
// [R13] Select 1: derate below 6 Hz over 100 %; restore under 88 % or over 7 Hz.
// [R14] Select 2: also derate above 7 Hz when current exceeds 112 %.
// [R15] Full range restore needs current 12 % under threshold and off-delay expiry.
// [R16] Off-delay 0.00-2.00 s, default 0.50 s; zero disables current derating.
// [R17] High current alarm enabled: over 150 % asserts alarm, closes code 10 output.
// [R18] Alarm select 0 (default): high current alarm never raised.
// [R19] Overheat derate enable 1: lower carrier while heatsink pre-alarm is active.
// [R20] Reduced speed rate is fraction of max frequency, 0-100 %, default 20 %.
// [R21] Comparisons run once per control tick; off-delay counted in ticks.
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "dps_consts.svh"
module dps_supervisor #(
   parameter int TICK_CYCLES = `DPS_TICK_US * 1000 / `DPS_CLK_NS
) (
   input wire logic clock, // Block clock, 200 MHz
   input wire logic reset_n, // Asynchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error, unmapped address
   input wire dps_pkg::dps_meas_type meas, // Sampled current and frequency
   input wire logic unbalance_detect, // Unbalance seen, asynchronous pin
   input wire logic supply_failure, // Cooling or contactor supply lost, pin
   input wire logic heatsink_overheat_prealarm, // Heatsink pre-alarm, pin
   output logic overcurrent_trip, // Sticky overcurrent fault
   output logic current_unbalance_fault, // Sticky unbalance fault
   output logic output_off, // Switch off inverter, motor coasts
   output dps_pkg::dps_stop_type stop_mode, // Stop request to speed controller
   output logic supply_error, // Supply failure classed as error
   output logic supply_alarm, // Supply failure alarm to keypad
   output logic speed_limit_en, // Reduced speed operation active
   output logic [15:0] speed_limit, // Reduced speed level, 0.01 Hz
   output logic high_current_alarm, // High current alarm level
   output logic alarm_output_close, // Digital output with alarm code closes
   output logic carrier_low, // Carrier frequency derated
   output logic [3:0] carrier_level // Derated carrier level in use
);
   localparam dps_pkg::dps_cfg_type CFG_RST = '{
      unb_en: 1'b1, hi_alarm_en: 1'b0, heat_derate_en: 1'b0, olpm: 1'b0,
      act: `DPS_RST_ACT, derate_sel: `DPS_RST_DSEL, mount: `DPS_RST_MOUNT,
      low_carrier: 4'h0, dout_fn: 8'h00, gain: `DPS_RST_GAIN,
      oc_level: `DPS_RST_OCLVL, motor_rated: `DPS_RST_MOTOR,
      delay: `DPS_RST_DELAY, rate: `DPS_RST_RATE, max_freq: `DPS_RST_MAXF};
   localparam dps_pkg::dps_state_type STATE_RST = '{
      cfg: CFG_RST, car: dps_pkg::car_normal, sf_kind: dps_pkg::stop_none,
      stop_mode: dps_pkg::stop_none, default: '0};
   localparam logic [11:0] TICKS_PER_UNIT = 12'(`DPS_DELAY_UNIT_MS * 1000 / `DPS_TICK_US);

   dps_pkg::dps_state_type q;
   dps_pkg::dps_state_type d;
   logic [15:0] oc_thr;
   logic set_lo;
   logic set_hi;
   logic derate_set;
   logic derate_clr;
   logic access;
   logic wr;
   logic fault_clr;
   logic [11:0] hold_end;

   // Scales a value by a setting in 0.1 % units, saturating at 16 bits
   function automatic logic [15:0] scale(input logic [15:0] v, input logic [11:0] g);
      logic [27:0] p;
      p = 28'(v) * 28'(g) / `DPS_SCALE;
      scale = (p[27:16] != 12'h000) ? 16'hFFFF : p[15:0];
   endfunction

   // Read view of the registers
   function automatic logic [31:0] rd(input dps_pkg::dps_state_type s, input logic [7:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      case (a)
         `DPS_OFS_CFG: begin
            r[`DPS_CFG_UNB] = s.cfg.unb_en;
            r[`DPS_CFG_HIA] = s.cfg.hi_alarm_en;
            r[`DPS_CFG_HEAT] = s.cfg.heat_derate_en;
            r[`DPS_CFG_OLPM] = s.cfg.olpm;
            r[`DPS_CFG_ACT +: 3] = s.cfg.act;
            r[`DPS_CFG_DSEL +: 2] = s.cfg.derate_sel;
            r[`DPS_CFG_MOUNT +: 2] = s.cfg.mount;
            r[`DPS_CFG_LOWCAR +: 4] = s.cfg.low_carrier;
            r[`DPS_CFG_DOFN +: 8] = s.cfg.dout_fn;
         end
         `DPS_OFS_GAIN: r[11:0] = s.cfg.gain;
         `DPS_OFS_LEVEL: r = {s.cfg.motor_rated, s.cfg.oc_level};
         `DPS_OFS_DELAY: r[7:0] = s.cfg.delay;
         `DPS_OFS_SPEED: r = {s.cfg.max_freq, 6'h00, s.cfg.rate};
         `DPS_OFS_STATUS: r[15:0] = {s.carrier_level, s.car, s.carrier_low, s.hi_alarm,
               s.speed_lim_en, s.sf_alarm, s.sf_err, s.lvl, s.unb_fault, s.oc_trip};
         default: r = 32'h0000_0000;
      endcase
      rd = r;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a <= `DPS_OFS_CMD) && (a[1:0] == 2'h0);
   endfunction

   // Trip threshold; gain only counts in open-loop magnet motor control
   always_comb begin
      oc_thr = q.cfg.oc_level;
      if (q.cfg.olpm && (scale(q.cfg.motor_rated, q.cfg.gain) < q.cfg.oc_level)) begin // [R1] [R2]
         oc_thr = scale(q.cfg.motor_rated, q.cfg.gain); // [R1]
      end
   end

   // Carrier derate and restore conditions
   always_comb begin
      set_lo = (meas.freq < `DPS_FREQ_6HZ) && (meas.current > `DPS_PCT_100); // [R13]
      set_hi = (meas.freq > `DPS_FREQ_7HZ) && (meas.current > `DPS_PCT_112); // [R14]
      case (q.cfg.derate_sel)
         2'h1: begin
            derate_set = set_lo; // [R13]
            derate_clr = (meas.current < `DPS_PCT_88) || (meas.freq > `DPS_FREQ_7HZ); // [R13]
         end
         2'h2: begin
            derate_set = set_lo || set_hi; // [R14]
            derate_clr = (meas.freq > `DPS_FREQ_7HZ) ? (meas.current < `DPS_PCT_100)
                  : (meas.current < `DPS_PCT_88); // [R15]
         end
         default: begin
            derate_set = 1'b0; // [R12]
            derate_clr = 1'b1;
         end
      endcase
   end

   assign access = psel && penable;
   assign wr = access && pwrite && q.pready;
   assign fault_clr = wr && (paddr == `DPS_OFS_CMD) && pwdata[0];
   assign hold_end = 12'(q.cfg.delay * TICKS_PER_UNIT) - 12'h001;

   // Next state of the whole supervisor
   always_comb begin
      d = q;
      // APB: ready one cycle into the access phase
      d.pready = access && !q.pready;
      d.pslverr = access && !q.pready && !mapped(paddr);
      if (access && !q.pready && !pwrite) begin
         d.prdata = rd(q, paddr);
      end
      if (wr) begin
         case (paddr)
            `DPS_OFS_CFG: begin
               d.cfg.unb_en = pwdata[`DPS_CFG_UNB];
               d.cfg.hi_alarm_en = pwdata[`DPS_CFG_HIA];
               d.cfg.heat_derate_en = pwdata[`DPS_CFG_HEAT];
               d.cfg.olpm = pwdata[`DPS_CFG_OLPM];
               if (pwdata[`DPS_CFG_ACT +: 3] <= `DPS_MAX_ACT) begin
                  d.cfg.act = pwdata[`DPS_CFG_ACT +: 3]; // [R5]
               end
               if (pwdata[`DPS_CFG_DSEL +: 2] != 2'h3) begin
                  d.cfg.derate_sel = pwdata[`DPS_CFG_DSEL +: 2];
               end
               if (pwdata[`DPS_CFG_MOUNT +: 2] != 2'h1) begin
                  d.cfg.mount = pwdata[`DPS_CFG_MOUNT +: 2]; // [R11]
               end
               d.cfg.low_carrier = pwdata[`DPS_CFG_LOWCAR +: 4];
               d.cfg.dout_fn = pwdata[`DPS_CFG_DOFN +: 8];
            end
            `DPS_OFS_GAIN: begin
               if (pwdata[11:0] <= `DPS_MAX_GAIN && pwdata[31:12] == 20'h00000) begin
                  d.cfg.gain = pwdata[11:0]; // [R1]
               end
            end
            `DPS_OFS_LEVEL: begin
               d.cfg.oc_level = pwdata[15:0];
               d.cfg.motor_rated = pwdata[31:16];
            end
            `DPS_OFS_DELAY: begin
               if (pwdata[7:0] <= `DPS_MAX_DELAY && pwdata[31:8] == 24'h000000) begin
                  d.cfg.delay = pwdata[7:0]; // [R16]
               end
            end
            `DPS_OFS_SPEED: begin
               if (pwdata[9:0] <= `DPS_MAX_RATE) begin
                  d.cfg.rate = pwdata[9:0]; // [R20]
               end
               d.cfg.max_freq = pwdata[31:16];
            end
            `DPS_OFS_CMD: begin
               if (pwdata[1]) begin
                  d.cfg = CFG_RST;
                  d.cfg.mount = q.cfg.mount; // [R11]
               end
            end
            default: d.cfg = q.cfg;
         endcase
      end
      // Control tick divider
      d.tick = (q.div == 24'(TICK_CYCLES - 1)); // [R21]
      d.div = d.tick ? 24'h000000 : q.div + 24'h000001;
      // Pin synchronisers: level moves once second and third stages agree
      d.s1 = {heatsink_overheat_prealarm, supply_failure, unbalance_detect};
      d.s2 = q.s1;
      d.s3 = q.s2;
      d.lvl = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.lvl);
      // Sticky faults; a new event wins over a clear
      d.unb_fault = (q.cfg.unb_en && q.lvl[0]) || (q.unb_fault && !fault_clr); // [R3] [R4]
      d.oc_trip = (q.tick && meas.current > oc_thr) || (q.oc_trip && !fault_clr); // [R1] [R21]
      // Supply failure action
      d.sf_latch = (q.lvl[1] && q.cfg.act <= 3'h2) || (q.sf_latch && !fault_clr);
      if (q.lvl[1] && !q.sf_latch) begin
         case (q.cfg.act)
            3'h0: d.sf_kind = dps_pkg::stop_ramp; // [R5]
            3'h1: d.sf_kind = dps_pkg::stop_coast; // [R6]
            3'h2: d.sf_kind = dps_pkg::stop_quick; // [R7]
            default: d.sf_kind = dps_pkg::stop_none;
         endcase
      end else if (!d.sf_latch) begin
         d.sf_kind = dps_pkg::stop_none;
      end
      d.sf_err = d.sf_latch && (d.sf_kind == dps_pkg::stop_ramp
            || d.sf_kind == dps_pkg::stop_quick); // [R10]
      d.sf_alarm = q.lvl[1] && (q.cfg.act == 3'h3 || q.cfg.act == 3'h4); // [R8] [R10]
      d.speed_lim_en = q.lvl[1] && (q.cfg.act == 3'h4); // [R9]
      d.speed_lim = scale(q.cfg.max_freq, {2'h0, q.cfg.rate}); // [R9] [R20]
      d.out_off = d.oc_trip || d.unb_fault || (d.sf_kind == dps_pkg::stop_coast); // [R3] [R6]
      if (d.out_off) begin
         d.stop_mode = dps_pkg::stop_coast;
      end else begin
         d.stop_mode = d.sf_kind;
      end
      // High current alarm, evaluated per tick
      if (q.tick) begin
         d.hi_alarm = q.cfg.hi_alarm_en && (meas.current > `DPS_PCT_150); // [R17] [R18]
      end
      d.do_close = d.hi_alarm && (q.cfg.dout_fn == `DPS_DOFN_ALARM); // [R17]
      // Carrier derate state machine with restore off-delay
      if (q.cfg.delay == 8'h00) begin
         d.car = dps_pkg::car_normal; // [R16]
         d.hold_cnt = 12'h000;
      end else if (q.tick) begin
         case (q.car)
            dps_pkg::car_normal: begin
               if (derate_set) begin
                  d.car = dps_pkg::car_derated; // [R13] [R14]
               end
            end
            dps_pkg::car_derated: begin
               d.hold_cnt = 12'h000;
               if (derate_clr) begin
                  d.car = dps_pkg::car_hold; // [R15]
               end
            end
            dps_pkg::car_hold: begin
               if (!derate_clr) begin
                  d.car = dps_pkg::car_derated;
               end else if (q.hold_cnt >= hold_end) begin
                  d.car = dps_pkg::car_normal; // [R15] [R16]
               end else begin
                  d.hold_cnt = q.hold_cnt + 12'h001; // [R21]
               end
            end
            default: d.car = dps_pkg::car_normal;
         endcase
      end
      d.carrier_low = (d.car != dps_pkg::car_normal)
            || (q.cfg.heat_derate_en && q.lvl[2]); // [R19]
      d.carrier_level = d.carrier_low ? q.cfg.low_carrier : 4'h0;
   end

   // State register
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         q <= STATE_RST;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from the state register
   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign overcurrent_trip = q.oc_trip;
   assign current_unbalance_fault = q.unb_fault;
   assign output_off = q.out_off;
   assign stop_mode = q.stop_mode;
   assign supply_error = q.sf_err;
   assign supply_alarm = q.sf_alarm;
   assign speed_limit_en = q.speed_lim_en;
   assign speed_limit = q.speed_lim;
   assign high_current_alarm = q.hi_alarm;
   assign alarm_output_close = q.do_close;
   assign carrier_low = q.carrier_low;
   assign carrier_level = q.carrier_level;

   // Checks
   a_oc_trip: assert property (@(posedge clock) disable iff (!reset_n) // [R1]
         q.tick && meas.current > oc_thr |=> q.oc_trip && q.out_off)
      else $error("overcurrent not tripped");
   a_unb_raise: assert property (@(posedge clock) disable iff (!reset_n) // [R3]
         q.cfg.unb_en && q.lvl[0] |=> q.unb_fault && q.stop_mode == dps_pkg::stop_coast)
      else $error("unbalance fault missing");
   a_unb_off: assert property (@(posedge clock) disable iff (!reset_n) // [R4]
         !q.cfg.unb_en && !q.unb_fault |=> !q.unb_fault)
      else $error("unbalance fault while disabled");
   a_supply_coast: assert property (@(posedge clock) disable iff (!reset_n) // [R6]
         q.lvl[1] && q.cfg.act == 3'h1 && !q.sf_latch |=> q.out_off)
      else $error("coast on supply failure missing");
   a_supply_alarm: assert property (@(posedge clock) disable iff (!reset_n) // [R10]
         q.lvl[1] && q.cfg.act == 3'h3 |=> q.sf_alarm && !q.speed_lim_en)
      else $error("supply alarm class wrong");
   a_mount_legal: assert property (@(posedge clock) disable iff (!reset_n) // [R11]
         q.cfg.mount != 2'h1)
      else $error("illegal mounting style held");
   a_no_derate: assert property (@(posedge clock) disable iff (!reset_n) // [R12]
         q.cfg.derate_sel == 2'h0 && q.car == dps_pkg::car_normal |=>
         q.car == dps_pkg::car_normal)
      else $error("carrier derated with select 0");
   a_delay_zero: assert property (@(posedge clock) disable iff (!reset_n) // [R16]
         q.cfg.delay == 8'h00 |=> q.car == dps_pkg::car_normal)
      else $error("derate active with zero off-delay");
   a_alarm_on: assert property (@(posedge clock) disable iff (!reset_n) // [R17]
         q.tick && q.cfg.hi_alarm_en && meas.current > `DPS_PCT_150 |=> q.hi_alarm)
      else $error("high current alarm missing");
   a_alarm_off: assert property (@(posedge clock) disable iff (!reset_n) // [R18]
         q.tick && !q.cfg.hi_alarm_en |=> !q.hi_alarm)
      else $error("high current alarm while disabled");
   a_heat_derate: assert property (@(posedge clock) disable iff (!reset_n) // [R19]
         q.cfg.heat_derate_en && q.lvl[2] |=> q.carrier_low)
      else $error("no derate during pre-alarm");
endmodule // dps_supervisor

// ---- inc/dps_consts.svh ----
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Currents in 0.1 % of drive rating, frequency in 0.01 Hz
// Notes: Included by the protection supervisor and its testbench
`ifndef DPS_CONSTS_SVH
`define DPS_CONSTS_SVH
// Register byte offsets
`define DPS_OFS_CFG 8'h00
`define DPS_OFS_GAIN 8'h04
`define DPS_OFS_LEVEL 8'h08
`define DPS_OFS_DELAY 8'h0C
`define DPS_OFS_SPEED 8'h10
`define DPS_OFS_STATUS 8'h14
`define DPS_OFS_CMD 8'h18
// Config field positions
`define DPS_CFG_UNB 0
`define DPS_CFG_HIA 1
`define DPS_CFG_HEAT 2
`define DPS_CFG_OLPM 3
`define DPS_CFG_ACT 4
`define DPS_CFG_DSEL 8
`define DPS_CFG_MOUNT 12
`define DPS_CFG_LOWCAR 16
`define DPS_CFG_DOFN 20
// Reset values
`define DPS_RST_GAIN 12'hBB8
`define DPS_RST_ACT 3'h1
`define DPS_RST_DSEL 2'h1
`define DPS_RST_MOUNT 2'h2
`define DPS_RST_OCLVL 16'h07D0
`define DPS_RST_MOTOR 16'h03E8
`define DPS_RST_DELAY 8'h32
`define DPS_RST_RATE 10'h0C8
`define DPS_RST_MAXF 16'h1770
// Limits and thresholds
`define DPS_MAX_GAIN 12'hBB8
`define DPS_MAX_ACT 3'h4
`define DPS_MAX_DELAY 8'hC8
`define DPS_MAX_RATE 10'h3E8
`define DPS_SCALE 28'h00003E8
`define DPS_PCT_88 16'h0370
`define DPS_PCT_100 16'h03E8
`define DPS_PCT_112 16'h0460
`define DPS_PCT_150 16'h05DC
`define DPS_FREQ_6HZ 16'h0258
`define DPS_FREQ_7HZ 16'h02BC
`define DPS_DOFN_ALARM 8'h10
// Timing
`define DPS_CLK_NS 5
`define DPS_TICK_US 1000
`define DPS_DELAY_UNIT_MS 10
`endif

// ---- inc/dps_pkg.sv ----
// Purpose: Types of the drive protection supervisor
// Assumes: Nothing beyond the constants header
// Notes: All state of the supervisor is one packed struct
package dps_pkg;
   typedef enum logic [1:0] {
      car_normal = 2'b00,
      car_derated = 2'b01,
      car_hold = 2'b11
   } dps_carrier_type;
   typedef enum logic [1:0] {
      stop_none = 2'b00,
      stop_ramp = 2'b01,
      stop_coast = 2'b10,
      stop_quick = 2'b11
   } dps_stop_type;
   typedef struct packed {
      logic [15:0] current;
      logic [15:0] freq;
   } dps_meas_type;
   typedef struct packed {
      logic unb_en;
      logic hi_alarm_en;
      logic heat_derate_en;
      logic olpm;
      logic [2:0] act;
      logic [1:0] derate_sel;
      logic [1:0] mount;
      logic [3:0] low_carrier;
      logic [7:0] dout_fn;
      logic [11:0] gain;
      logic [15:0] oc_level;
      logic [15:0] motor_rated;
      logic [7:0] delay;
      logic [9:0] rate;
      logic [15:0] max_freq;
   } dps_cfg_type;
   typedef struct packed {
      dps_cfg_type cfg;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [23:0] div;
      logic tick;
      logic [2:0] s1;
      logic [2:0] s2;
      logic [2:0] s3;
      logic [2:0] lvl;
      dps_carrier_type car;
      logic [11:0] hold_cnt;
      logic oc_trip;
      logic unb_fault;
      logic sf_latch;
      dps_stop_type sf_kind;
      dps_stop_type stop_mode;
      logic out_off;
      logic sf_err;
      logic sf_alarm;
      logic speed_lim_en;
      logic [15:0] speed_lim;
      logic hi_alarm;
      logic do_close;
      logic carrier_low;
      logic [3:0] carrier_level;
   } dps_state_type;
endpackage

// ---- tb/dps_plant.sv ----
// Purpose: Power stage and current sensing model facing the supervisor
// Assumes: Commanded values change right after a rising edge
// Notes: Measurements are registered every clock, like a sampling converter
`timescale 1ns/100ps
module dps_plant (
   input wire logic clock, // Block clock
   input wire logic reset_n, // Reset, active low
   input wire logic [15:0] cur_cmd, // Wanted current, 0.1 %
   input wire logic [15:0] freq_cmd, // Wanted frequency, 0.01 Hz
   input wire logic [2:0] pin_cmd, // Unbalance, supply, heat requests
   output dps_pkg::dps_meas_type meas, // Sampled measurement
   output logic [2:0] pins // Fault pins, unbalance at bit 0
);
   // Converter samples each cycle; pins follow the stage state
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         meas <= '0;
         pins <= 3'h0;
      end else begin
         meas <= {cur_cmd, freq_cmd};
         pins <= pin_cmd;
      end
   end
endmodule // dps_plant

// ---- tb/dps_supervisor_tb_top.sv ----
// Purpose: Self-checking bench of the drive protection supervisor
// Assumes: Control tick shortened to 10 clocks
// Notes: Random gains, currents and rates from a fixed seed, with corner cases
`timescale 1ns/100ps
`include "dps_consts.svh"
module dps_supervisor_tb_top;
   localparam int TK = 10;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, oc, unb, off, serr, salm, slen, hia, aclose, clow;
   logic [15:0] cur = 16'h0;
   logic [15:0] frq = 16'h0;
   logic [15:0] slim;
   logic [3:0] clev;
   logic [2:0] pin = 3'h0;
   logic [2:0] pins;
   dps_pkg::dps_meas_type meas;
   dps_pkg::dps_stop_type smode;
   dps_pkg::dps_stop_type sx [5] = '{dps_pkg::stop_ramp, dps_pkg::stop_coast,
      dps_pkg::stop_quick, dps_pkg::stop_none, dps_pkg::stop_none};
   int num_errors = 0;
   int n_tests = 0;
   int seed = 32'h31d0;
   // Clock of 5 ns period
   always #2.5 clock = ~clock;
   dps_plant i_plant (.clock(clock), .reset_n(reset_n), .cur_cmd(cur), .freq_cmd(frq),
      .pin_cmd(pin), .meas(meas), .pins(pins));
   dps_supervisor #(.TICK_CYCLES(TK)) i_dut (.clock(clock), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .meas(meas), .unbalance_detect(pins[0]),
      .supply_failure(pins[1]), .heatsink_overheat_prealarm(pins[2]),
      .overcurrent_trip(oc), .current_unbalance_fault(unb), .output_off(off),
      .stop_mode(smode), .supply_error(serr), .supply_alarm(salm), .speed_limit_en(slen),
      .speed_limit(slim), .high_current_alarm(hia), .alarm_output_close(aclose),
      .carrier_low(clow), .carrier_level(clev));
   // Verdict and end of run
   task automatic finish_test;
      $display("errors %0d, checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // One comparison of a result word
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_tests++;
      if (got !== ex) begin
         num_errors++;
         $display("[ERR] %s expected %0h seen %0h", nm, ex, got);
      end
   endtask
   // APB transfer; answer taken at the edge where pready is high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
         num_errors++;
         finish_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Three control ticks: one tick of answer plus pin synchroniser
   task automatic settle;
      repeat (3 * TK) @(posedge clock);
   endtask
   // Config word: f = {olpm, heat, alarm, unbalance}, mount 2, low carrier 5
   function automatic logic [31:0] cfgw(input logic [2:0] act, input logic [3:0] f,
      input logic [1:0] ds);
      return {4'h0, `DPS_DOFN_ALARM, 4'h5, 2'h0, 2'h2, 2'h0, ds, 1'b0, act, f};
   endfunction
   // Hang guard
   initial begin
      repeat (100000) @(posedge clock);
      num_errors++;
      finish_test();
   end
   // Main sequence
   initial begin
      logic [31:0] ex [5];
      int thr, g, c, o;
      ex = '{{18'h0, `DPS_RST_MOUNT, 2'h0, `DPS_RST_DSEL, 1'b0, `DPS_RST_ACT, 4'h1},
         {20'h0, `DPS_RST_GAIN}, {`DPS_RST_MOTOR, `DPS_RST_OCLVL}, {24'h0, `DPS_RST_DELAY},
         {`DPS_RST_MAXF, 6'h0, `DPS_RST_RATE}};
      repeat (10) @(posedge clock);
      reset_n <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         chk("reset value", ex[i], rd);
      end
      apb(1'b0, 8'h1C, 32'h0);
      chk("unmapped", 32'h1, {31'h0, err});
      apb(1'b1, `DPS_OFS_GAIN, 32'hBB9);
      apb(1'b0, `DPS_OFS_GAIN, 32'h0);
      chk("gain", 32'hBB8, rd);
      // Action 5, derate select 3 and mount 1 are all refused
      apb(1'b1, `DPS_OFS_CFG, 32'h1351);
      apb(1'b0, `DPS_OFS_CFG, 32'h0);
      chk("mount", 32'h2110, rd & 32'h3370);
      apb(1'b1, `DPS_OFS_CFG, 32'h3232);
      apb(1'b1, `DPS_OFS_CMD, 32'h2);
      apb(1'b0, `DPS_OFS_CFG, 32'h0);
      chk("init", 32'h3111, rd);
      // Trip level against own level and scaled motor current
      for (int i = 0; i < 8; i++) begin
         o = (i == 0) ? 1 : (i == 1) ? 0 : $random(seed) & 1;
         g = (i == 0) ? 1000 : {$random(seed)} % 3001;
         c = (i < 2) ? 1100 : {$random(seed)} % 4000;
         thr = (o == 1 && g < 2000) ? g : 2000;
         c = (c == thr) ? c + 1 : c;
         apb(1'b1, `DPS_OFS_GAIN, g);
         apb(1'b1, `DPS_OFS_CFG, cfgw(3'h3, {o[0], 3'h1}, 2'h0));
         cur <= c[15:0];
         settle();
         chk("trip", {31'h0, c > thr}, {31'h0, oc});
         chk("off", {31'h0, c > thr}, {31'h0, off});
         cur <= 16'h0;
         settle();
         apb(1'b1, `DPS_OFS_CMD, 32'h1);
      end
      // Unbalance with detection off, then on
      apb(1'b1, `DPS_OFS_CFG, cfgw(3'h3, 4'h0, 2'h0));
      pin <= 3'b001;
      settle();
      chk("unbalance", 32'h0, {31'h0, unb});
      apb(1'b1, `DPS_OFS_CFG, cfgw(3'h3, 4'h1, 2'h0));
      settle();
      chk("unbalance", 32'h1, {31'h0, unb});
      chk("off", 32'h1, {31'h0, off});
      pin <= 3'b000;
      settle();
      apb(1'b1, `DPS_OFS_CMD, 32'h1);
      // Every supply failure action
      for (int a = 0; a < 5; a++) begin
         g = {$random(seed)} % 1001;
         apb(1'b1, `DPS_OFS_SPEED, {`DPS_RST_MAXF, 6'h0, g[9:0]});
         apb(1'b1, `DPS_OFS_CFG, cfgw(a[2:0], 4'h0, 2'h0));
         pin <= 3'b010;
         settle();
         chk("stop", {30'h0, sx[a]}, {30'h0, smode});
         chk("off", {31'h0, a == 1}, {31'h0, off});
         chk("error", {31'h0, a == 0 || a == 2}, {31'h0, serr});
         chk("alarm", {31'h0, a > 2}, {31'h0, salm});
         chk("slow", {31'h0, a == 4}, {31'h0, slen});
         // The level is always shown; the enable says when it applies
         chk("limit", `DPS_RST_MAXF * g / 1000, {16'h0, slim});
         pin <= 3'b000;
         settle();
         apb(1'b1, `DPS_OFS_CMD, 32'h1);
      end
      // High current alarm disabled, enabled, below level
      cur <= 16'd1600;
      apb(1'b1, `DPS_OFS_CFG, cfgw(3'h3, 4'h0, 2'h0));
      settle();
      chk("hi alarm", 32'h0, {31'h0, hia | aclose});
      apb(1'b1, `DPS_OFS_CFG, cfgw(3'h3, 4'h2, 2'h0));
      settle();
      chk("hi alarm", 32'h3, {30'h0, hia, aclose});
      cur <= 16'd1400;
      settle();
      chk("hi alarm", 32'h0, {31'h0, hia});
      // Carrier derating, hold and restore; off-delay above 2.00 s refused
      apb(1'b1, `DPS_OFS_DELAY, 32'h2);
      apb(1'b1, `DPS_OFS_DELAY, 32'hC9);
      apb(1'b0, `DPS_OFS_DELAY, 32'h0);
      chk("delay", 32'h2, rd);
      frq <= 16'd500;
      cur <= 16'd1100;
      settle();
      chk("carrier", 32'h0, {31'h0, clow});
      apb(1'b1, `DPS_OFS_CFG, cfgw(3'h3, 4'h0, 2'h1));
      settle();
      chk("carrier", 32'h1, {31'h0, clow});
      cur <= 16'd800;
      settle();
      chk("carrier", 32'h1, {31'h0, clow});
      repeat (30 * TK) @(posedge clock);
      chk("carrier", 32'h0, {31'h0, clow});
      frq <= 16'd800;
      cur <= 16'd1150;
      settle();
      chk("carrier", 32'h0, {31'h0, clow});
      apb(1'b1, `DPS_OFS_CFG, cfgw(3'h3, 4'h0, 2'h2));
      settle();
      chk("carrier", 32'h1, {31'h0, clow});
      apb(1'b1, `DPS_OFS_DELAY, 32'h0);
      settle();
      chk("carrier", 32'h0, {31'h0, clow});
      apb(1'b1, `DPS_OFS_CFG, cfgw(3'h3, 4'h4, 2'h2));
      pin <= 3'b100;
      settle();
      chk("carrier", 32'h15, {27'h0, clow, clev});
      apb(1'b1, `DPS_OFS_CFG, cfgw(3'h3, 4'h0, 2'h2));
      settle();
      chk("carrier", 32'h0, {31'h0, clow});
      finish_test();
   end
endmodule // dps_supervisor_tb_top
